//--- usx_pkg.sv
// Shared constants, types and helpers of the synchronous slave transmit path.
package usx_pkg;

	// ----------------------------------------------------------------
	// Transmit control/status field positions and reset value
	// ----------------------------------------------------------------
	localparam int           CLK_SRC_POS   = 7;
	localparam int           NINE_SEL_POS  = 6;
	localparam int           TX_EN_POS     = 5;
	localparam int           SYNC_POS      = 4;
	localparam int           BRK_POS       = 3;
	localparam int           HI_SPD_POS    = 2;
	localparam int           SH_EMPTY_POS  = 1;
	localparam int           NINTH_POS     = 0;
	localparam logic [7:0]   TCS_RESET     = 8'h02;

	// ----------------------------------------------------------------
	// Queued word layout: {frame is nine bits, ninth data bit, byte}
	// ----------------------------------------------------------------
	localparam int           DATA_W        = 8;
	localparam int           SHIFT_W       = 9;
	localparam int           WORD_W        = 10;
	localparam int           WORD_NINE_POS = 9;
	localparam int           HOLD_DEPTH    = 2;
	localparam logic [3:0]   BITS_SHORT    = 4'h8;
	localparam logic [3:0]   BITS_LONG     = 4'h9;

	// ----------------------------------------------------------------
	// Link timing of the clocking end
	// ----------------------------------------------------------------
	localparam int           SYS_PERIOD_NS = 25;
	localparam int           LINK_HALF_NS  = 100;
	localparam int           HALF_CYC      = (LINK_HALF_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
	localparam logic [2:0]   HALF_LOAD     = 3'(HALF_CYC - 1);

	// ----------------------------------------------------------------
	// Clocking end states
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		HS_IDLE = 3'h1,
		HS_HIGH = 3'h2,
		HS_LOW  = 3'h4
	} usx_host_state_e;

	// Number of bits in one frame for the selected word length.
	function automatic logic [3:0] usx_frame_bits(input logic nine);
		return nine ? BITS_LONG : BITS_SHORT;
	endfunction

endpackage

//--- usx_link_if.sv
// Link between the slave transmitter and the clocking receiver.
`timescale 1ns/100ps
interface usx_link_if;
	logic ck_out;
	logic ck_oe_n;
	logic dt_out;
	logic dt_oe_n;
	logic req_tgl;
	logic frame_nine;
	logic ck;
	logic dt;

	// The clock wire idles low and the data wire idles high when undriven.
	assign ck = ck_oe_n ? 1'b0 : ck_out;
	assign dt = dt_oe_n ? 1'b1 : dt_out;

	modport dev (input ck, output dt_out, output dt_oe_n, output req_tgl, output frame_nine);
	modport mst (output ck_out, output ck_oe_n, input dt, input req_tgl, input frame_nine);
endinterface

//--- usx_pair_buf.sv
// Small valid/ready word buffer used as the transmit holding stage.
`timescale 1ns/100ps
module usx_pair_buf #(
	parameter int W     = 10,
	parameter int DEPTH = 2
) (
	// Clock and reset
	input  wire logic         i_clk,
	input  wire logic         i_rst,
	// Filling side
	input  wire logic         i_in_valid,
	input  wire logic [W-1:0] i_in_data,
	output logic              o_in_ready,
	// Draining side
	output logic              o_out_valid,
	output logic [W-1:0]      o_out_data,
	input  wire logic         i_out_ready
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [W-1:0]  mem_r [DEPTH];
	logic [AW-1:0] wp_r;
	logic [AW-1:0] rp_r;
	logic [AW:0]   cnt_r;
	logic          push;
	logic          pop;

	function automatic logic [AW-1:0] nxt_ptr(input logic [AW-1:0] p);
		return (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
	endfunction

	assign o_in_ready  = cnt_r != (AW+1)'(DEPTH);
	assign o_out_valid = cnt_r != '0;
	assign o_out_data  = mem_r[rp_r];
	assign push        = i_in_valid & o_in_ready;
	assign pop         = o_out_valid & i_out_ready;

	always_ff @(posedge i_clk) begin
		if (push) begin
			mem_r[wp_r] <= i_in_data;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end else begin
			if (push) begin
				wp_r <= nxt_ptr(wp_r);
			end
			if (pop) begin
				rp_r <= nxt_ptr(rp_r);
			end
			if (push && !pop) begin
				cnt_r <= cnt_r + 1'b1;
			end else if (pop && !push) begin
				cnt_r <= cnt_r - 1'b1;
			end
		end
	end
endmodule // usx_pair_buf

//--- usx_slave_tx.sv
// Synchronous slave transmitter: control/status, holding stage and link shifter.
`timescale 1ns/100ps

// Function
// - Clock source bit: set master, clear slave; setting it here only blocks slave transmit, no clock is driven.
// - Ninth-bit select picks nine or eight bits.
// - Bit four selects synchronous or asynchronous mode.
// - Async break request, cleared by hardware after.
// - High-speed select stored, used only asynchronously; no logic here acts on it in either mode.
// - Shift-empty status reads one when shifter idle.
// - Bit zero holds the ninth data bit.
// - Clear clock source in sync means slave.
// - Slave shifting runs from link clock, even asleep.
// - First queued word moves to shifter immediately.
// - Second word waits; interrupt flag stays clear.
// - Second word moves, then flag sets.
// - Flag with enable wakes; with globals, branches.
// - Software sets sync, port enable, clears receives.
// - Software sets enables before enabling transmitter.
// - Ninth bit loaded before byte; byte starts.
// - Software sets global and peripheral enables.
module usx_slave_tx
	import usx_pkg::*;
(
	// System clock and reset
	input  wire logic              i_clk,
	input  wire logic              i_rst,
	// Link
	usx_link_if.dev                lnk,
	// Transmit control/status register port
	input  wire logic              i_tcs_wr,
	input  wire logic [7:0]        i_tcs_wdata,
	output logic      [7:0]        o_tcs_rdata,
	// Transmit holding register port
	input  wire logic              i_hold_wr,
	input  wire logic [DATA_W-1:0] i_hold_data,
	output logic                   o_hold_ready,
	// Receive control and interrupt control bits
	input  wire logic              i_serial_port_enable,
	input  wire logic              i_single_receive_enable,
	input  wire logic              i_continuous_receive_enable,
	input  wire logic              i_transmit_interrupt_enable,
	input  wire logic              i_global_interrupt_enable,
	input  wire logic              i_peripheral_interrupt_enable,
	input  wire logic              i_sleep,
	// Status and wake
	output logic                   o_transmit_interrupt_flag,
	output logic                   o_wake,
	output logic                   o_branch_vector
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic                clock_source_select_r;
	logic                nine_bit_select_r;
	logic                transmitter_enable_r;
	logic                sync_mode_r;
	logic                break_request_r;
	logic                high_speed_select_r;
	logic                ninth_data_bit_r;
	logic                stage_full_r;
	logic [WORD_W-1:0]   stage_word_r;
	logic                req_tgl_r;
	logic                flag_r;
	logic                dt_oe_n_r;
	logic                done_s1_r;
	logic                done_s2_r;
	logic                done_s3_r;
	logic                done_pulse;
	logic                slave_on;
	logic                async_on;
	logic                buf_in_valid;
	logic [WORD_W-1:0]   buf_in_word;
	logic                buf_out_valid;
	logic [WORD_W-1:0]   buf_out_word;
	logic                buf_out_ready;
	logic                pop;
	// Link domain
	logic [SHIFT_W-1:0]  sh_r;
	logic [3:0]          cnt_r;
	logic                dt_r;
	logic                done_tgl_r;

	// ----------------------------------------------------------------
	// Mode decode
	// ----------------------------------------------------------------
	// Slave transmit runs only in synchronous mode with external clock and
	// both receive enables clear, since a receive enable overrides transmit.
	assign slave_on = sync_mode_r & !clock_source_select_r & i_serial_port_enable
		& transmitter_enable_r & !i_single_receive_enable
		& !i_continuous_receive_enable;
	assign async_on = !sync_mode_r & i_serial_port_enable & transmitter_enable_r;

	// ----------------------------------------------------------------
	// Control/status register
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			clock_source_select_r <= TCS_RESET[CLK_SRC_POS];
			nine_bit_select_r     <= TCS_RESET[NINE_SEL_POS];
			transmitter_enable_r  <= TCS_RESET[TX_EN_POS];
			sync_mode_r           <= TCS_RESET[SYNC_POS];
			high_speed_select_r   <= TCS_RESET[HI_SPD_POS];
			ninth_data_bit_r      <= TCS_RESET[NINTH_POS];
		end else if (i_tcs_wr) begin
			clock_source_select_r <= i_tcs_wdata[CLK_SRC_POS];
			nine_bit_select_r     <= i_tcs_wdata[NINE_SEL_POS];
			transmitter_enable_r  <= i_tcs_wdata[TX_EN_POS];
			sync_mode_r           <= i_tcs_wdata[SYNC_POS];
			high_speed_select_r   <= i_tcs_wdata[HI_SPD_POS];
			ninth_data_bit_r      <= i_tcs_wdata[NINTH_POS];
		end
	end

	// Break request: software sets it, an asynchronous transmission clears
	// it; a set in the same cycle as the clear wins.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			break_request_r <= TCS_RESET[BRK_POS];
		end else if (i_tcs_wr && i_tcs_wdata[BRK_POS]) begin
			break_request_r <= 1'b1;
		end else if (pop && async_on) begin
			break_request_r <= 1'b0;
		end
	end

	always_comb begin
		o_tcs_rdata               = 8'h00;
		o_tcs_rdata[CLK_SRC_POS]  = clock_source_select_r;
		o_tcs_rdata[NINE_SEL_POS] = nine_bit_select_r;
		o_tcs_rdata[TX_EN_POS]    = transmitter_enable_r;
		o_tcs_rdata[SYNC_POS]     = sync_mode_r;
		o_tcs_rdata[BRK_POS]      = break_request_r;
		o_tcs_rdata[HI_SPD_POS]   = high_speed_select_r;
		o_tcs_rdata[SH_EMPTY_POS] = !stage_full_r;
		o_tcs_rdata[NINTH_POS]    = ninth_data_bit_r;
	end

	// ----------------------------------------------------------------
	// Holding stage
	// ----------------------------------------------------------------
	// The ninth bit and word length are caught with the byte, so the ninth
	// bit must already be in place when the byte is written.
	assign buf_in_valid = i_hold_wr & !i_sleep;
	assign buf_in_word  = {nine_bit_select_r, ninth_data_bit_r, i_hold_data};
	// The shift stage takes a word only once the link side has shown the last bit of the previous one.
	assign buf_out_ready = sync_mode_r ? (slave_on & !stage_full_r) : async_on;
	assign pop           = buf_out_valid & buf_out_ready;

	usx_pair_buf #(
		.W     (WORD_W),
		.DEPTH (HOLD_DEPTH)
	) u_hold (
		.i_clk       (i_clk),
		.i_rst       (i_rst),
		.i_in_valid  (buf_in_valid),
		.i_in_data   (buf_in_word),
		.o_in_ready  (o_hold_ready),
		.o_out_valid (buf_out_valid),
		.o_out_data  (buf_out_word),
		.i_out_ready (buf_out_ready)
	);

	// ----------------------------------------------------------------
	// Shift stage hand-off to the link domain
	// ----------------------------------------------------------------
	// The staged word stays unchanged from the request toggle until the
	// link side reports the last bit, so the link side may read it directly.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			stage_full_r <= 1'b0;
			req_tgl_r    <= 1'b0;
		end else if (pop && sync_mode_r) begin
			stage_full_r <= 1'b1;
			req_tgl_r    <= !req_tgl_r;
		end else if (done_pulse) begin
			stage_full_r <= 1'b0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (pop && sync_mode_r) begin
			stage_word_r <= buf_out_word;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			done_s1_r <= 1'b0;
			done_s2_r <= 1'b0;
			done_s3_r <= 1'b0;
		end else begin
			done_s1_r <= done_tgl_r;
			done_s2_r <= done_s1_r;
			done_s3_r <= done_s2_r;
		end
	end

	assign done_pulse = done_s2_r ^ done_s3_r;

	// ----------------------------------------------------------------
	// Interrupt flag, wake and pin enable
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			flag_r    <= 1'b1;
			dt_oe_n_r <= 1'b1;
		end else begin
			flag_r    <= !buf_out_valid;
			dt_oe_n_r <= !slave_on;
		end
	end

	assign o_transmit_interrupt_flag = flag_r;
	assign o_wake          = flag_r & i_transmit_interrupt_enable;
	assign o_branch_vector = o_wake & i_global_interrupt_enable
		& i_peripheral_interrupt_enable;

	// ----------------------------------------------------------------
	// Link-side shifter
	// ----------------------------------------------------------------
	// Runs on the external clock alone, so it keeps going while the
	// system side sleeps. The first edge of a frame loads and shows bit 0.
	always_ff @(posedge lnk.ck or posedge i_rst) begin
		if (i_rst) begin
			sh_r       <= '0;
			cnt_r      <= 4'h0;
			dt_r       <= 1'b1;
			done_tgl_r <= 1'b0;
		end else if (cnt_r == 4'h0) begin
			dt_r  <= stage_word_r[0];
			sh_r  <= {1'b0, stage_word_r[SHIFT_W-1:1]};
			cnt_r <= usx_frame_bits(stage_word_r[WORD_NINE_POS]) - 4'h1;
		end else begin
			dt_r  <= sh_r[0];
			sh_r  <= {1'b0, sh_r[SHIFT_W-1:1]};
			cnt_r <= cnt_r - 4'h1;
			if (cnt_r == 4'h1) begin
				done_tgl_r <= !done_tgl_r;
			end
		end
	end

	assign lnk.dt_out     = dt_r;
	assign lnk.dt_oe_n    = dt_oe_n_r;
	assign lnk.req_tgl    = req_tgl_r;
	assign lnk.frame_nine = stage_word_r[WORD_NINE_POS];

endmodule // usx_slave_tx

//--- usx_master_rx.sv
// Clocking receiver: drives the shift clock and collects each word.
`timescale 1ns/100ps
module usx_master_rx
	import usx_pkg::*;
(
	// System clock and reset
	input  wire logic               i_clk,
	input  wire logic               i_rst,
	// Link
	usx_link_if.mst                 lnk,
	// Received words
	output logic                    o_rx_valid,
	output logic [SHIFT_W-1:0]      o_rx_data,
	input  wire logic               i_rx_ready
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	usx_host_state_e     state_r;
	logic                req_s1_r;
	logic                req_s2_r;
	logic                dt_s1_r;
	logic                dt_s2_r;
	logic                seen_r;
	logic                ck_r;
	logic [2:0]          hc_r;
	logic [3:0]          idx_r;
	logic [3:0]          bits_r;
	logic [SHIFT_W-1:0]  acc_r;

	// ----------------------------------------------------------------
	// Synchronisers
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			req_s1_r <= 1'b0;
			req_s2_r <= 1'b0;
			dt_s1_r  <= 1'b1;
			dt_s2_r  <= 1'b1;
		end else begin
			req_s1_r <= lnk.req_tgl;
			req_s2_r <= req_s1_r;
			dt_s1_r  <= lnk.dt;
			dt_s2_r  <= dt_s1_r;
		end
	end

	// ----------------------------------------------------------------
	// Frame sequencer
	// ----------------------------------------------------------------
	// Exactly one clock pulse per bit; the bit shown at a rising edge is
	// sampled at the end of the following low half.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state_r    <= HS_IDLE;
			seen_r     <= 1'b0;
			ck_r       <= 1'b0;
			hc_r       <= 3'h0;
			idx_r      <= 4'h0;
			bits_r     <= BITS_SHORT;
			acc_r      <= '0;
			o_rx_valid <= 1'b0;
			o_rx_data  <= '0;
		end else begin
			if (o_rx_valid && i_rx_ready) begin
				o_rx_valid <= 1'b0;
			end
			unique case (state_r)
				HS_IDLE: begin
					// The request is taken as the frame starts, so a word staged
					// while the last bit is still being sampled is not lost.
					if (req_s2_r != seen_r && !o_rx_valid) begin
						seen_r  <= req_s2_r;
						ck_r    <= 1'b1;
						hc_r    <= HALF_LOAD;
						idx_r   <= 4'h0;
						acc_r   <= '0;
						bits_r  <= usx_frame_bits(lnk.frame_nine);
						state_r <= HS_HIGH;
					end
				end
				HS_HIGH: begin
					if (hc_r == 3'h0) begin
						ck_r    <= 1'b0;
						hc_r    <= HALF_LOAD;
						state_r <= HS_LOW;
					end else begin
						hc_r <= hc_r - 3'h1;
					end
				end
				HS_LOW: begin
					if (hc_r != 3'h0) begin
						hc_r <= hc_r - 3'h1;
					end else if (idx_r == bits_r - 4'h1) begin
						o_rx_valid <= 1'b1;
						o_rx_data  <= acc_r | (SHIFT_W'(dt_s2_r) << idx_r);
						state_r    <= HS_IDLE;
					end else begin
						acc_r[idx_r] <= dt_s2_r;
						idx_r        <= idx_r + 4'h1;
						ck_r         <= 1'b1;
						hc_r         <= HALF_LOAD;
						state_r      <= HS_HIGH;
					end
				end
			endcase
		end
	end

	assign lnk.ck_out  = ck_r;
	assign lnk.ck_oe_n = 1'b0;

endmodule // usx_master_rx

//--- usx_link_chk.sv
// Link checker between the slave transmitter and the clocking receiver.
`timescale 1ns/100ps
module usx_link_chk
	import usx_pkg::*;
(
	// Clock and reset
	input  wire logic i_clk,
	input  wire logic i_rst,
	// Link signals
	input  wire logic ck_out,
	input  wire logic ck_oe_n,
	input  wire logic dt_out,
	input  wire logic dt_oe_n,
	input  wire logic req_tgl,
	input  wire logic frame_nine,
	input  wire logic ck,
	input  wire logic dt
);
	// ----------------------------------------------------------------
	// Helper logic
	// ----------------------------------------------------------------
	logic       ck_q_r;
	logic       tgl_q_r;
	logic [3:0] cnt_r;
	logic [3:0] bits_r;
	logic       ck_rise;
	logic       tgl_chg;

	assign ck_rise = ck & !ck_q_r;
	assign tgl_chg = req_tgl != tgl_q_r;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			ck_q_r  <= 1'b0;
			tgl_q_r <= 1'b0;
		end else begin
			ck_q_r  <= ck;
			tgl_q_r <= req_tgl;
		end
	end

	// Edges are counted per staged word; the length is taken at the first edge.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			cnt_r  <= 4'h0;
			bits_r <= BITS_SHORT;
		end else if (tgl_chg) begin
			cnt_r <= 4'h0;
		end else if (ck_rise) begin
			cnt_r <= cnt_r + 4'h1;
			if (cnt_r == 4'h0) begin
				bits_r <= frame_nine ? BITS_LONG : BITS_SHORT;
			end
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_rst);

	sequence s_ck_high;
		ck [*4];
	endsequence
	sequence s_ck_low;
		!ck [*4];
	endsequence

	a_ck_always_driven: assert property (!ck_oe_n && ck == ck_out)
		else $error("shift clock not driven by the clocking end");
	a_ck_high_low: assert property (ck_rise |-> s_ck_high ##1 s_ck_low)
		else $error("shift clock phase length wrong");
	a_dt_on_edge: assert property ($changed(dt_out) |-> ck_rise)
		else $error("data changed away from a rising shift clock");
	a_dt_driven_edge: assert property (ck_rise |-> !dt_oe_n && dt == dt_out)
		else $error("data not driven during a shift clock edge");
	a_edge_bound: assert property (ck_rise |-> cnt_r < (frame_nine ? BITS_LONG : BITS_SHORT))
		else $error("more shift clock edges than frame bits");
	a_frame_count: assert property (tgl_chg |-> (cnt_r == 4'h0 || cnt_r == bits_r))
		else $error("frame ended with a wrong edge count");
	a_nine_stable: assert property (ck_rise |-> $stable(frame_nine))
		else $error("word length changed inside a frame");
	a_tgl_spacing: assert property (tgl_chg |=> !tgl_chg [*8])
		else $error("two words staged back to back");
endmodule // usx_link_chk

//--- sync_serial_transmitter_tb_top.sv
// Self-checking bench for the slave transmitter facing the clocking receiver.
`timescale 1ns/100ps
module sync_serial_transmitter_tb_top
	import usx_pkg::*;
;
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic               i_clk;
	logic               i_rst;
	logic               i_tcs_wr;
	logic [7:0]         i_tcs_wdata;
	logic [7:0]         o_tcs_rdata;
	logic               i_hold_wr;
	logic [DATA_W-1:0]  i_hold_data;
	logic               o_hold_ready;
	logic               i_serial_port_enable;
	logic               i_single_receive_enable;
	logic               i_continuous_receive_enable;
	logic               i_transmit_interrupt_enable;
	logic               i_global_interrupt_enable;
	logic               i_peripheral_interrupt_enable;
	logic               i_sleep;
	logic               o_transmit_interrupt_flag;
	logic               o_wake;
	logic               o_branch_vector;
	logic               o_rx_valid;
	logic [SHIFT_W-1:0] o_rx_data;
	logic               i_rx_ready;
	int                 errors;
	int                 check_count;

	usx_link_if u_usx_link_if ();

	usx_slave_tx u_usx_slave_tx (
		.i_clk(i_clk), .i_rst(i_rst), .lnk(u_usx_link_if),
		.i_tcs_wr(i_tcs_wr), .i_tcs_wdata(i_tcs_wdata), .o_tcs_rdata(o_tcs_rdata),
		.i_hold_wr(i_hold_wr), .i_hold_data(i_hold_data), .o_hold_ready(o_hold_ready),
		.i_serial_port_enable(i_serial_port_enable),
		.i_single_receive_enable(i_single_receive_enable),
		.i_continuous_receive_enable(i_continuous_receive_enable),
		.i_transmit_interrupt_enable(i_transmit_interrupt_enable),
		.i_global_interrupt_enable(i_global_interrupt_enable),
		.i_peripheral_interrupt_enable(i_peripheral_interrupt_enable),
		.i_sleep(i_sleep), .o_transmit_interrupt_flag(o_transmit_interrupt_flag),
		.o_wake(o_wake), .o_branch_vector(o_branch_vector));

	usx_master_rx u_usx_master_rx (
		.i_clk(i_clk), .i_rst(i_rst), .lnk(u_usx_link_if),
		.o_rx_valid(o_rx_valid), .o_rx_data(o_rx_data), .i_rx_ready(i_rx_ready));

	usx_link_chk u_usx_link_chk (
		.i_clk(i_clk), .i_rst(i_rst),
		.ck_out(u_usx_link_if.ck_out), .ck_oe_n(u_usx_link_if.ck_oe_n),
		.dt_out(u_usx_link_if.dt_out), .dt_oe_n(u_usx_link_if.dt_oe_n),
		.req_tgl(u_usx_link_if.req_tgl), .frame_nine(u_usx_link_if.frame_nine),
		.ck(u_usx_link_if.ck), .dt(u_usx_link_if.dt));

	always #12.5 i_clk = ~i_clk;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic step(input int n);
		repeat (n) begin
			@(posedge i_clk);
			#2;
		end
	endtask
	task automatic chk_bit(input string nm, input logic e, input logic g);
		check_count++;
		if (g !== e) begin
			errors++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_reg(input string nm, input logic [7:0] e, input logic [7:0] g);
		check_count++;
		if (g !== e) begin
			errors++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_word(input logic [SHIFT_W-1:0] e);
		check_count++;
		if (o_rx_data !== e) begin
			errors++;
			$display("FAIL rx_data expected %h seen %h", e, o_rx_data);
		end
	endtask
	task automatic wr_tcs(input logic [7:0] d);
		i_tcs_wdata = d;
		i_tcs_wr = 1'b1;
		step(1);
		i_tcs_wr = 1'b0;
		step(1);
	endtask
	task automatic wr_hold(input logic [7:0] d);
		i_hold_data = d;
		i_hold_wr = 1'b1;
		step(1);
		i_hold_wr = 1'b0;
		step(1);
	endtask
	task automatic wait_rx();
		for (int i = 0; i < 400 && o_rx_valid !== 1'b1; i++) step(1);
		chk_bit("rx_valid", 1'b1, o_rx_valid);
	endtask
	task automatic get_word(input logic [SHIFT_W-1:0] e);
		wait_rx();
		chk_word(e);
		i_rx_ready = 1'b1;
		step(1);
		i_rx_ready = 1'b0;
		step(1);
	endtask
	task automatic end_of_test();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		chk_reg("tcs", TCS_RESET, o_tcs_rdata);
		chk_bit("flag", 1'b1, o_transmit_interrupt_flag);
		chk_bit("dt", 1'b1, u_usx_link_if.dt);
	endtask
	task automatic t_async();
		wr_tcs(8'h2C);
		chk_reg("tcs", 8'h2E, o_tcs_rdata);
		wr_hold(8'h55);
		step(10);
		chk_reg("tcs", 8'h26, o_tcs_rdata);
		chk_bit("rx_valid", 1'b0, o_rx_valid);
	endtask
	task automatic t_send();
		wr_tcs(8'h30);
		chk_reg("tcs", 8'h32, o_tcs_rdata);
		wr_hold(8'hA5);
		chk_bit("empty", 1'b0, o_tcs_rdata[SH_EMPTY_POS]);
		get_word(9'h0A5);
		step(6);
		chk_bit("empty", 1'b1, o_tcs_rdata[SH_EMPTY_POS]);
		wr_tcs(8'h51);
		wr_tcs(8'h71);
		wr_hold(8'h3C);
		get_word(9'h13C);
		wr_tcs(8'h70);
		wr_hold(8'hC3);
		get_word(9'h0C3);
	endtask
	task automatic t_block();
		for (int k = 0; k < 3; k++) begin
			case (k)
				0: wr_tcs(8'hB0);
				1: i_single_receive_enable = 1'b1;
				default: i_continuous_receive_enable = 1'b1;
			endcase
			wr_hold(8'h11 + 8'(k));
			step(40);
			chk_bit("rx_valid", 1'b0, o_rx_valid);
			chk_bit("dt", 1'b1, u_usx_link_if.dt);
			chk_bit("empty", 1'b1, o_tcs_rdata[SH_EMPTY_POS]);
			i_single_receive_enable = 1'b0;
			i_continuous_receive_enable = 1'b0;
			wr_tcs(8'h30);
			get_word({1'b0, 8'h11 + 8'(k)});
		end
	endtask
	task automatic t_sleep();
		wr_hold(8'h81);
		wr_hold(8'h42);
		i_sleep = 1'b1;
		step(20);
		chk_bit("flag", 1'b0, o_transmit_interrupt_flag);
		wait_rx();
		step(10);
		chk_bit("flag", 1'b1, o_transmit_interrupt_flag);
		chk_bit("wake", 1'b0, o_wake);
		i_transmit_interrupt_enable = 1'b1;
		step(1);
		chk_bit("wake", 1'b1, o_wake);
		chk_bit("branch", 1'b0, o_branch_vector);
		i_global_interrupt_enable = 1'b1;
		i_peripheral_interrupt_enable = 1'b1;
		step(1);
		chk_bit("branch", 1'b1, o_branch_vector);
		get_word(9'h081);
		get_word(9'h042);
		i_sleep = 1'b0;
	endtask
	task automatic t_fill();
		for (int k = 0; k < 3; k++) wr_hold(8'hD0 + 8'(k));
		chk_bit("hold_ready", 1'b0, o_hold_ready);
		wr_hold(8'hEE);
		for (int k = 0; k < 3; k++) get_word({1'b0, 8'hD0 + 8'(k)});
		step(200);
		chk_bit("rx_valid", 1'b0, o_rx_valid);
	endtask

	// ----------------------------------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		i_clk = 1'b0;
		i_rst = 1'b1;
		i_tcs_wr = 1'b0;
		i_tcs_wdata = 8'h00;
		i_hold_wr = 1'b0;
		i_hold_data = 8'h00;
		i_serial_port_enable = 1'b1;
		i_single_receive_enable = 1'b0;
		i_continuous_receive_enable = 1'b0;
		i_transmit_interrupt_enable = 1'b0;
		i_global_interrupt_enable = 1'b0;
		i_peripheral_interrupt_enable = 1'b0;
		i_sleep = 1'b0;
		i_rx_ready = 1'b0;
		errors = 0;
		check_count = 0;
		step(10);
		i_rst = 1'b0;
		step(1);
		t_reset();
		t_async();
		t_send();
		t_block();
		t_sleep();
		t_fill();
		end_of_test();
	end

	initial begin
		#(25 * 20000);
		errors++;
		end_of_test();
	end
endmodule // sync_serial_transmitter_tb_top
